/* File: rtl/ltp_timer_pair.sv */
// two legacy counter/timers behind an apb slave.
// assumes event and gate pins are already synchronous to pclk, and that the
// interrupt controller pulses an acknowledge when it vectors to a timer.
//
// Operation
// - timer counts ticks of clock over 1 or 12
// - counter counts falling edges on event pin
// - events up to half clock rate counted
// - prescale bits 4 and 3 pick divide
// - bits 6 and 5 stored, else ignored
// - divider bit 7 and bits 2-0 read zero
// - 16-bit count as two byte registers
// - each timer has own mode field
// - 13-bit mode uses high byte plus five
// - top three low bits undefined in 13-bit
// - wrap from 1fff sets overflow flag
// - source bit picks clock or events
// - run and (gate clear or pin high)
// - setting run keeps the count
// - timer one mirrors timer zero, but idles in mode 11 and loses events and its flag while timer zero is split
// - mode field decodes four modes
// - mode 01 counts all sixteen bits
// - flag cleared by software or acknowledge
`default_nettype none

module ltp_timer_pair
    import ltp_pkg::*;
#(
    parameter int PADDR_W = 12  // apb address width
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               event_input_pin_a,
    input  wire logic               event_input_pin_b,
    input  wire logic               gate_input_zero,
    input  wire logic               gate_input_one,
    input  wire logic               ovf_ack_zero,
    input  wire logic               ovf_ack_one,
    output logic                    timer_zero_overflow_flag,
    output logic                    timer_one_overflow_flag
);

    // register state
    logic [1:0][7:0] lo_r;          // low bytes, index = timer
    logic [1:0][7:0] hi_r;          // high bytes
    logic [1:0][7:0] lo_nxt;        // low bytes after counting
    logic [1:0][7:0] hi_nxt;        // high bytes after counting
    logic [1:0]      run_r;         // run bits
    logic [1:0]      ovf_r;         // overflow flags
    logic [7:0]      mode_r;        // timer_mode_register
    logic [6:3]      ckdiv_r;       // implemented bits of divider select
    logic [3:0]      pre_cnt_r;     // divide-by-12 counter
    logic            slow_tick_r;   // one-cycle pulse every 12 clocks
    logic [1:0]      ev_now_r;      // current event pin samples
    logic [1:0]      ev_old_r;      // previous event pin samples
    logic [31:0]     prdata_r;      // read data, sampled in setup
    logic            pready_r;      // high from the first edge after reset
    logic            pslverr_r;     // unmapped address answer

    // apb decode
    logic [7:0]  idx;         // word index
    logic        aligned_ok;  // low bits zero and no stray high bits
    logic        setup_ph;    // setup cycle
    logic        wr_en;       // write takes effect at this edge
    logic        hit_ctrl;
    logic        hit_mode;
    logic        hit_ckdiv;
    logic [1:0]  hit_lo;
    logic [1:0]  hit_hi;
    logic        mapped;
    logic [7:0]  rd_byte;     // selected read value
    logic [7:0]  wbyte;       // low byte of write data

    assign idx        = paddr[9:2];
    assign aligned_ok = (paddr[1:0] == 2'b00) && (paddr[PADDR_W-1:10] == '0);
    assign setup_ph   = psel && !penable;
    // slave always answers in the first access cycle
    assign wr_en      = psel && penable && pwrite && pready_r;
    assign wbyte      = pwdata[7:0];
    assign hit_ctrl   = aligned_ok && (idx == LTP_IDX_CTRL);
    assign hit_mode   = aligned_ok && (idx == LTP_IDX_MODE);
    assign hit_ckdiv  = aligned_ok && (idx == LTP_IDX_CKDIV);
    assign hit_lo[0]  = aligned_ok && (idx == LTP_IDX_T0LO);
    assign hit_lo[1]  = aligned_ok && (idx == LTP_IDX_T1LO);
    assign hit_hi[0]  = aligned_ok && (idx == LTP_IDX_T0HI);
    assign hit_hi[1]  = aligned_ok && (idx == LTP_IDX_T1HI);
    assign mapped     = hit_ctrl || hit_mode || hit_ckdiv || (|hit_lo) || (|hit_hi);

    // read mux; interrupt type bits of the control register are not built
    assign rd_byte =
        hit_ctrl  ? {ovf_r[1], run_r[1], ovf_r[0], run_r[0], 4'h0} :
        hit_mode  ? mode_r :
        // unused and reserved bits read zero
        hit_ckdiv ? {1'b0, ckdiv_r, 3'b000} :
        hit_lo[0] ? lo_r[0] :
        hit_lo[1] ? lo_r[1] :
        hit_hi[0] ? hi_r[0] :
        hit_hi[1] ? hi_r[1] : 8'h00;

    // pin and mode decode per timer
    logic [1:0] ev_pin;       // raw event pins
    logic [1:0] gate_pin;     // raw gate pins
    logic [1:0] ev_fall;      // falling edge seen
    logic [1:0] fast_sel;     // prescale select, 1 = undivided
    logic [1:0] sys_tick;     // prescaled system tick
    logic [1:0] src_ext;      // external source in use
    logic [1:0] enabled;      // run and gate condition
    logic [1:0] step;         // count this cycle
    ltp_mode_t  mode_of [2];  // decoded mode fields
    logic       split0;       // timer zero in split mode
    logic       hi0_step;     // split high byte counts
    logic [1:0] ack;          // overflow acknowledges

    assign ev_pin   = {event_input_pin_b, event_input_pin_a};
    assign gate_pin = {gate_input_one, gate_input_zero};
    assign ack      = {ovf_ack_one, ovf_ack_zero};
    // bit 3 for timer zero, bit 4 for timer one
    assign fast_sel = {ckdiv_r[LTP_CKDIV_T1], ckdiv_r[LTP_CKDIV_T0]};

    for (genvar i = 0; i < 2; i++) begin : g_dec
        // each timer reads its own field
        assign mode_of[i] = ltp_mode_t'(mode_r[LTP_MODE_STRIDE*i+LTP_MODE_SEL_LO +: 2]);
        // tick is clock or clock over twelve
        assign sys_tick[i] = fast_sel[i] | slow_tick_r;
        // falling edge from two clocked samples
        assign ev_fall[i]  = ev_old_r[i] & ~ev_now_r[i];
        // run, then gate clear or gate pin high
        assign enabled[i]  = run_r[i] &&
                             (!mode_r[LTP_MODE_STRIDE*i+LTP_MODE_GATE] || gate_pin[i]);
    end

    assign split0 = (mode_of[0] == LTP_SPLIT);
    // source bit picks events or ticks; timer one loses events in split
    assign src_ext[0] = mode_r[LTP_MODE_SRC];
    assign src_ext[1] = mode_r[LTP_MODE_STRIDE+LTP_MODE_SRC] && !split0;
    // counter function steps on each falling edge
    assign step[0] = enabled[0] && (src_ext[0] ? ev_fall[0] : sys_tick[0]);
    // timer one steps like timer zero
    assign step[1] = enabled[1] && (src_ext[1] ? ev_fall[1] : sys_tick[1]);
    // split high byte: plain timer on timer zero's tick, run by timer one's bit
    assign hi0_step = split0 && run_r[1] && sys_tick[0];

    // counting and overflow detection
    logic [1:0]  wrap;    // counter wrapped, per owning flag
    logic [12:0] c13;     // 13-bit working value
    logic [15:0] c16;     // 16-bit working value

    always_comb begin
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        wrap   = 2'b00;
        c13    = 13'h0000;
        c16    = 16'h0000;
        for (int i = 0; i < 2; i++) begin
            if (step[i]) begin
                unique case (mode_of[i])
                    LTP_MODE13: begin
                        // high byte over low five bits
                        c13 = {hi_r[i], lo_r[i][4:0]};
                        // wrap from all ones raises the flag
                        wrap[i] = (c13 == 13'h1fff);
                        c13 = 13'(c13 + 13'h0001);
                        hi_nxt[i] = c13[12:5];
                        // top low bits left as they were, meaningless
                        lo_nxt[i][4:0] = c13[4:0];
                    end
                    LTP_MODE16: begin
                        c16 = {hi_r[i], lo_r[i]};
                        wrap[i] = (c16 == 16'hffff);
                        c16 = 16'(c16 + 16'h0001);
                        {hi_nxt[i], lo_nxt[i]} = c16;
                    end
                    LTP_RELOAD8: begin
                        // high byte holds the reload value
                        wrap[i] = (lo_r[i] == 8'hff);
                        lo_nxt[i] = wrap[i] ? hi_r[i] : 8'(lo_r[i] + 8'h01);
                    end
                    LTP_SPLIT: begin
                        // timer zero low byte counts; timer one sits idle
                        if (i == 0) begin
                            wrap[0] = (lo_r[0] == 8'hff);
                            lo_nxt[0] = 8'(lo_r[0] + 8'h01);
                        end
                    end
                endcase
            end
        end
        // split high byte borrows timer one's flag
        if (hi0_step) begin
            wrap[1] = (hi_r[0] == 8'hff);
            hi_nxt[0] = 8'(hi_r[0] + 8'h01);
        end else if (split0) begin
            // timer one may not raise its own flag while split
            wrap[1] = 1'b0;
        end
    end

    // flag next values: hardware set wins over software write and acknowledge
    logic [1:0] ovf_nxt;
    logic [1:0] wr_ovf;
    assign wr_ovf = {wbyte[LTP_CTRL_OVF1], wbyte[LTP_CTRL_OVF0]};
    for (genvar i = 0; i < 2; i++) begin : g_flag
        assign ovf_nxt[i] = wrap[i] ? 1'b1 :
                            (wr_en && hit_ctrl) ? wr_ovf[i] :
                            ack[i] ? 1'b0 : ovf_r[i];
    end

    // prescaler: one slow tick every twelve clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r   <= 4'h0;
            slow_tick_r <= 1'b0;
        end else begin
            pre_cnt_r   <= (pre_cnt_r == LTP_PRESCALE_LAST) ? 4'h0 : 4'(pre_cnt_r + 4'h1);
            slow_tick_r <= (pre_cnt_r == LTP_PRESCALE_LAST);
        end
    end

    // event pin samples; each pin must hold a level one clock to be seen
    // one sample per clock catches half-rate events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_now_r <= 2'b00;
            ev_old_r <= 2'b00;
        end else begin
            ev_now_r <= ev_pin;
            ev_old_r <= ev_now_r;
        end
    end

    // count bytes: a software write wins over the count in that cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_r <= {2{LTP_RST_COUNT}};
            hi_r <= {2{LTP_RST_COUNT}};
        end else begin
            for (int i = 0; i < 2; i++) begin
                lo_r[i] <= (wr_en && hit_lo[i]) ? wbyte : lo_nxt[i];
                hi_r[i] <= (wr_en && hit_hi[i]) ? wbyte : hi_nxt[i];
            end
        end
    end

    // control, mode and divider registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r   <= {LTP_RST_CTRL[LTP_CTRL_RUN1], LTP_RST_CTRL[LTP_CTRL_RUN0]};
            ovf_r   <= {LTP_RST_CTRL[LTP_CTRL_OVF1], LTP_RST_CTRL[LTP_CTRL_OVF0]};
            mode_r  <= LTP_RST_MODE;
            ckdiv_r <= LTP_RST_CKDIV[6:3];
        end else begin
            ovf_r <= ovf_nxt;
            // run bit touches no count byte
            if (wr_en && hit_ctrl) begin
                run_r <= {wbyte[LTP_CTRL_RUN1], wbyte[LTP_CTRL_RUN0]};
            end
            if (wr_en && hit_mode) begin
                mode_r <= wbyte;
            end
            // bits 6 and 5 kept for software only
            // bit 7 and bits 2-0 are never stored
            if (wr_en && hit_ckdiv) begin
                ckdiv_r <= wbyte[6:3];
            end
        end
    end

    // apb answer: data and error caught in setup, ready high from reset on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            if (setup_ph) begin
                prdata_r  <= {24'h00_0000, rd_byte};
                pslverr_r <= !mapped;
            end
        end
    end

    // outputs straight from flip-flops
    assign prdata                   = prdata_r;
    assign pready                   = pready_r;
    assign pslverr                  = pslverr_r;
    assign timer_zero_overflow_flag = ovf_r[0];
    assign timer_one_overflow_flag  = ovf_r[1];

endmodule : ltp_timer_pair

`default_nettype wire

/* File: rtl/ltp_pkg.sv */
// package for the legacy timer pair: register indices, field positions,
// reset values, prescale constants and the mode encoding.
// assumes an apb slave with 32-bit data, one register per aligned word.
`default_nettype none

package ltp_pkg;

    // register indices; byte address on apb is four times the index
    localparam logic [7:0] LTP_IDX_CTRL  = 8'h88;  // run bits and overflow flags
    localparam logic [7:0] LTP_IDX_MODE  = 8'h89;  // mode, source and gate fields
    localparam logic [7:0] LTP_IDX_T0LO  = 8'h8a;  // timer zero low byte
    localparam logic [7:0] LTP_IDX_T1LO  = 8'h8b;  // timer one low byte
    localparam logic [7:0] LTP_IDX_T0HI  = 8'h8c;  // timer zero high byte
    localparam logic [7:0] LTP_IDX_T1HI  = 8'h8d;  // timer one high byte
    localparam logic [7:0] LTP_IDX_CKDIV = 8'h8e;  // clock divider select

    // reset values
    localparam logic [7:0] LTP_RST_CTRL  = 8'h00;
    localparam logic [7:0] LTP_RST_MODE  = 8'h00;
    localparam logic [7:0] LTP_RST_COUNT = 8'h00;
    localparam logic [7:0] LTP_RST_CKDIV = 8'h00;

    // control register fields
    localparam int LTP_CTRL_RUN0 = 4;  // timer zero run
    localparam int LTP_CTRL_OVF0 = 5;  // timer zero overflow flag
    localparam int LTP_CTRL_RUN1 = 6;  // timer one run
    localparam int LTP_CTRL_OVF1 = 7;  // timer one overflow flag

    // mode register fields, per timer at offset 4*i
    localparam int LTP_MODE_STRIDE = 4;
    localparam int LTP_MODE_SEL_LO = 0;  // two-bit mode field starts here
    localparam int LTP_MODE_SRC    = 2;  // source select, 1 = external events
    localparam int LTP_MODE_GATE   = 3;  // gate enable

    // clock divider select fields
    localparam int LTP_CKDIV_T0 = 3;  // timer zero prescale select
    localparam int LTP_CKDIV_T1 = 4;  // timer one prescale select
    localparam int LTP_CKDIV_T2 = 5;  // timer two prescale select, stored only
    localparam int LTP_CKDIV_T4 = 6;  // timer four prescale select, stored only

    // slow tick is the system clock divided by this figure
    localparam int         LTP_PRESCALE_DIV  = 12;
    localparam logic [3:0] LTP_PRESCALE_LAST = 4'(LTP_PRESCALE_DIV - 1);

    // mode field encoding, declaration order gives codes 00..11
    typedef enum logic [1:0] {
        LTP_MODE13,   // 13-bit counter
        LTP_MODE16,   // 16-bit counter
        LTP_RELOAD8,  // 8-bit auto-reload
        LTP_SPLIT     // split (timer zero) or inactive (timer one)
    } ltp_mode_t;

endpackage : ltp_pkg

`default_nettype wire

/* File: testbench/ltp_timer_pair_chk.sv */
// checker for the timer pair: apb answers, register read rules, flag hold.
// assumes it is bound to ltp_timer_pair and sees only its ports.
`default_nettype none

module ltp_timer_pair_chk
    import ltp_pkg::*;
#(
    parameter int PADDR_W = 12
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               ovf_ack_zero,
    input wire logic               ovf_ack_one,
    input wire logic               timer_zero_overflow_flag,
    input wire logic               timer_one_overflow_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic [7:0] idx    = paddr[9:2];  // word index of the access
    wire logic       acc    = psel && penable;  // access phase
    wire logic       mapped = (paddr[1:0] == 2'b00) && (paddr[PADDR_W-1:10] == '0)
                              && (idx >= LTP_IDX_CTRL) && (idx <= LTP_IDX_CKDIV);
    wire logic       rd_ctl = acc && !pwrite && (idx == LTP_IDX_CTRL) && mapped;
    wire logic       rd_ck  = acc && !pwrite && (idx == LTP_IDX_CKDIV) && mapped;
    wire logic       wr_ctl = acc && pwrite && (idx == LTP_IDX_CTRL) && mapped;
    // only an ack or a software write of zero may drop a flag
    wire logic       clr0   = ovf_ack_zero || (wr_ctl && !pwdata[LTP_CTRL_OVF0]);
    wire logic       clr1   = ovf_ack_one || (wr_ctl && !pwdata[LTP_CTRL_OVF1]);

    a_ready_access: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ckdiv_rsvd: assert property (rd_ck |-> prdata[7] == 1'b0 && prdata[2:0] == 3'h0)
        else $error("divider reserved bits not zero");
    a_ctrl_flags: assert property (rd_ctl |-> prdata[3:0] == 4'h0 &&
        prdata[5] == $past(timer_zero_overflow_flag) && prdata[7] == $past(timer_one_overflow_flag))
        else $error("control read does not show flags");
    a_flag0_hold: assert property ($fell(timer_zero_overflow_flag) |-> $past(clr0))
        else $error("flag zero dropped without clear");
    a_flag1_hold: assert property ($fell(timer_one_overflow_flag) |-> $past(clr1))
        else $error("flag one dropped without clear");
    a_ready_stays: assert property (pready |=> pready)
        else $error("pready fell");
endmodule : ltp_timer_pair_chk

bind ltp_timer_pair ltp_timer_pair_chk #(.PADDR_W(PADDR_W)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ovf_ack_zero(ovf_ack_zero), .ovf_ack_one(ovf_ack_one),
    .timer_zero_overflow_flag(timer_zero_overflow_flag),
    .timer_one_overflow_flag(timer_one_overflow_flag));

`default_nettype wire

/* File: testbench/ltp_pin_model.sv */
// model of the external event and gate sources.
// assumes pins are sampled on rising pclk; events idle high.
`default_nettype none

module ltp_pin_model (
    input  wire logic pclk,
    output logic      event_input_pin_a,
    output logic      event_input_pin_b,
    output logic      gate_input_zero,
    output logic      gate_input_one
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: events high so no false falling edge, gates closed
    initial begin
        event_input_pin_a = 1'b1;
        event_input_pin_b = 1'b1;
        gate_input_zero   = 1'b0;
        gate_input_one    = 1'b0;
    end

    task automatic pulse(input logic sel_b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            if (sel_b) event_input_pin_b <= 1'b0;
            else event_input_pin_a <= 1'b0;
            repeat (2) @(posedge pclk);
            event_input_pin_a <= 1'b1;
            event_input_pin_b <= 1'b1;
            @(posedge pclk);
        end
        // let the two sample flops drain
        repeat (3) @(posedge pclk);
    endtask : pulse

    task automatic set_gate(input logic sel_b, input logic lvl);
        @(posedge pclk);
        if (sel_b) gate_input_one <= lvl;
        else gate_input_zero <= lvl;
        @(posedge pclk);
    endtask : set_gate
endmodule : ltp_pin_model

`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the timer pair: apb tasks and pin model.
// assumes the register map of ltp_pkg; the apb master waits for pready however long.
`default_nettype none

module tb;
    import ltp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, ack0 = 1'b0, ack1 = 1'b0;
    logic        ev_a, ev_b, gt0, gt1, f0, f1;
    int          n_fail = 0, n_tests = 0;

    always #25 pclk = ~pclk;  // 20 MHz

    ltp_timer_pair i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_input_pin_a(ev_a), .event_input_pin_b(ev_b), .gate_input_zero(gt0),
        .gate_input_one(gt1), .ovf_ack_zero(ack0), .ovf_ack_one(ack1),
        .timer_zero_overflow_flag(f0), .timer_one_overflow_flag(f1));

    ltp_pin_model i_pins (.pclk(pclk), .event_input_pin_a(ev_a), .event_input_pin_b(ev_b),
        .gate_input_zero(gt0), .gate_input_one(gt1));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    // one transfer; request held until pready seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge: the next call never re-raises psel in this time step
        @(posedge pclk);
    endtask : apb

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] msk);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        chk(rd & {24'h0, msk}, {24'h0, exp & msk});
    endtask : rd_chk

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rd_chk(LTP_IDX_CTRL + 8'(i), 8'h00, 8'hff);
        apb(1'b0, 12'h23c, 8'h00);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 12'h040, 8'h55);
        chk({31'h0, err}, 32'h1);
        // bit 7 written high to prove it is dropped; reserved bits 2-0 written zero
        wr_reg(LTP_IDX_CKDIV, 8'hf8);
        rd_chk(LTP_IDX_CKDIV, 8'h78, 8'hff);
        $display("test registers done");
        // timer zero undivided from 0x1ffc, timer one divided by 12
        wr_reg(LTP_IDX_CKDIV, 8'h08);
        wr_reg(LTP_IDX_T0HI, 8'hff);
        wr_reg(LTP_IDX_T0LO, 8'h1c);
        wr_reg(LTP_IDX_CTRL, 8'h50);
        repeat (117) @(posedge pclk);
        chk({31'h0, f0}, 32'h1);
        wr_reg(LTP_IDX_CTRL, 8'h00);
        chk({31'h0, f0}, 32'h0);
        rd_chk(LTP_IDX_T0HI, 8'h03, 8'hff);
        rd_chk(LTP_IDX_T0LO, 8'h14, 8'h1f);
        rd_chk(LTP_IDX_T1LO, 8'h0a, 8'hff);
        rd_chk(LTP_IDX_T1HI, 8'h00, 8'hff);
        $display("test timer done");
        // counters: timer zero 13-bit gated, timer one 16-bit free
        wr_reg(LTP_IDX_MODE, 8'h5c);
        rd_chk(LTP_IDX_MODE, 8'h5c, 8'hff);
        wr_reg(LTP_IDX_T0LO, 8'h00);
        wr_reg(LTP_IDX_T0HI, 8'h00);
        wr_reg(LTP_IDX_T1LO, 8'hfe);
        wr_reg(LTP_IDX_T1HI, 8'hff);
        wr_reg(LTP_IDX_CTRL, 8'h50);
        i_pins.pulse(1'b0, 3);
        i_pins.set_gate(1'b0, 1'b1);
        i_pins.pulse(1'b0, 5);
        i_pins.pulse(1'b1, 2);
        chk({31'h0, f1}, 32'h1);
        wr_reg(LTP_IDX_CTRL, 8'h80);
        rd_chk(LTP_IDX_T0LO, 8'h05, 8'h1f);
        rd_chk(LTP_IDX_T1LO, 8'h00, 8'hff);
        rd_chk(LTP_IDX_T1HI, 8'h00, 8'hff);
        rd_chk(LTP_IDX_CTRL, 8'h80, 8'hff);
        ack1 <= 1'b1;
        @(posedge pclk);
        ack1 <= 1'b0;
        @(posedge pclk);
        chk({31'h0, f1}, 32'h0);
        $display("test counter done");
        // auto-reload on timer zero, timer one inactive
        wr_reg(LTP_IDX_MODE, 8'h32);
        wr_reg(LTP_IDX_T0HI, 8'hf0);
        wr_reg(LTP_IDX_T0LO, 8'hfc);
        wr_reg(LTP_IDX_CTRL, 8'h50);
        repeat (4) @(posedge pclk);
        chk({30'h0, f1, f0}, 32'h1);
        wr_reg(LTP_IDX_CTRL, 8'h00);
        rd_chk(LTP_IDX_T0LO, 8'hf3, 8'hff);
        rd_chk(LTP_IDX_T0HI, 8'hf0, 8'hff);
        rd_chk(LTP_IDX_T1LO, 8'h00, 8'hff);
        // split timer zero: high byte runs on run one and raises flag one
        wr_reg(LTP_IDX_MODE, 8'h03);
        wr_reg(LTP_IDX_T0LO, 8'hfe);
        wr_reg(LTP_IDX_T0HI, 8'hff);
        wr_reg(LTP_IDX_CTRL, 8'h50);
        repeat (2) @(posedge pclk);
        chk({30'h0, f1, f0}, 32'h3);
        wr_reg(LTP_IDX_CTRL, 8'h00);
        rd_chk(LTP_IDX_T0LO, 8'h03, 8'hff);
        rd_chk(LTP_IDX_T0HI, 8'h04, 8'hff);
        $display("test modes done");
        give_verdict();
    end
endmodule : tb

`default_nettype wire
